// [sbsc_defines.vh]
`ifndef SBSC_DEFINES_VH
`define SBSC_DEFINES_VH

// geometry
`define SBSC_ADDR_W 18
`define SBSC_DATA_W 16
`define SBSC_PAR_W 2
`define SBSC_WORD_W 18
`define SBSC_DEPTH 262144
// byte lane layout
`define SBSC_LANE0_DQ_LSB 0
`define SBSC_LANE1_DQ_LSB 8
`define SBSC_LANE_DQ_W 8
// burst order select levels
`define SBSC_ORDER_LINEAR 1'b0
`define SBSC_ORDER_INTERLEAVE 1'b1
// data fifo
`define SBSC_FIFO_DEPTH 16
`define SBSC_FIFO_AW 4
// reset values
`define SBSC_RST_BURST_CNT 2'h0
`define SBSC_RST_OP 3'h1

`endif

// [sbsc_fifo.v]
module sbsc_fifo #(
   parameter WIDTH = 18,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   // fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   // drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0] count_q;
   wire push;
   wire pop;

   assign in_ready_o = (count_q != DEPTH[AW:0]);
   assign out_valid_o = (count_q != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data_i;
      end
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         case ({push, pop})
            2'b10: count_q <= count_q + 1'b1;
            2'b01: count_q <= count_q - 1'b1;
            default: count_q <= count_q;
         endcase
      end
   end
endmodule // sbsc_fifo

// [sbsc_burst_addr.v]
`include "sbsc_defines.vh"

module sbsc_burst_addr (
   // start value and step count
   input wire [1:0] start_i,
   input wire [1:0] count_i,
   input wire order_i,
   // stepped low address bits
   output wire [1:0] addr_o
);
   // interleave xors the count, linear adds it mod four
   assign addr_o = (order_i == `SBSC_ORDER_INTERLEAVE) ? (start_i ^ count_i) // R8 R14
                                                       : (start_i + count_i); // R9
endmodule // sbsc_burst_addr

// [sbsc_core.v]
// Behaviour
// [R1] deselect tristates data after next edge; code tristates it only after the fourth edge after the deselect edge
// [R2] qualifier high freezes every state; code still drains the write fifo and updates data_oe_o, parity_io_oe_o and busy_o
// [R3] all three selects active to select
// [R4] load latches address, write strobe picks
// [R5] master drives write data two edges later
// [R6] advance after read continues burst read
// [R7] advance after write continues burst write
// [R8] interleaved order xors start with count
// [R9] linear order adds count modulo four
// [R10] byte lane selects mask stored bytes
// [R11] each lane covers byte plus parity
// [R12] data drive from cycle and output enable
// [R13] powers up deselected, outputs disabled
// [R14] order input low linear, high interleaved
// [R15] read data out edge after load; code drives it only after the fourth edge after the load edge
// [R16] write data beat never drives pins
`include "sbsc_defines.vh"

module sbsc_core (
   // clock and reset
   input wire clk_sys_i,
   input wire rst_i,
   // control pins
   input wire clock_qualify_n_i,
   input wire advance_or_load_i,
   input wire chip_sel1_n_i,
   input wire chip_sel2_i,
   input wire chip_sel3_n_i,
   input wire write_n_i,
   input wire [1:0] byte_lane_select_n_i,
   input wire burst_order_i,
   input wire out_drive_n_i,
   input wire [`SBSC_ADDR_W-1:0] addr_i,
   // data and parity pins
   input wire [`SBSC_DATA_W-1:0] data_i,
   output reg [`SBSC_DATA_W-1:0] data_o,
   output reg data_oe_o,
   input wire [`SBSC_PAR_W-1:0] parity_io_i,
   output reg [`SBSC_PAR_W-1:0] parity_io_o,
   output reg parity_io_oe_o,
   // cycle status
   output reg busy_o
);
   localparam OP_IDLE = 3'b001;
   localparam OP_READ = 3'b010;
   localparam OP_WRITE = 3'b100;

   // two-flop pin synchronisers, one generate over all pin bits
   localparam PIN_W = 8 + `SBSC_ADDR_W + `SBSC_WORD_W + 2;
   wire [PIN_W-1:0] pin_raw;
   wire [PIN_W-1:0] pin_s;
   assign pin_raw = {clock_qualify_n_i, advance_or_load_i, chip_sel1_n_i, chip_sel2_i,
                     chip_sel3_n_i, write_n_i, byte_lane_select_n_i, addr_i,
                     parity_io_i, data_i, burst_order_i, out_drive_n_i};
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
         reg meta_q;
         reg sync_q;
         always @(posedge clk_sys_i) begin
            meta_q <= pin_raw[gi];
            sync_q <= meta_q;
         end
         assign pin_s[gi] = sync_q;
      end
   endgenerate

   wire qual_n = pin_s[PIN_W-1];
   wire adv = pin_s[PIN_W-2];
   wire cs1_n = pin_s[PIN_W-3];
   wire cs2 = pin_s[PIN_W-4];
   wire cs3_n = pin_s[PIN_W-5];
   wire wr_n = pin_s[PIN_W-6];
   wire [1:0] bls_n = pin_s[PIN_W-7:PIN_W-8];
   wire [`SBSC_ADDR_W-1:0] addr = pin_s[PIN_W-9:PIN_W-8-`SBSC_ADDR_W];
   wire [`SBSC_WORD_W-1:0] wdata = pin_s[`SBSC_WORD_W+1:2];
   wire order = pin_s[1];
   wire oe_n = pin_s[0];

   wire step = ~qual_n; // R2
   wire cs_act = ~cs1_n & cs2 & ~cs3_n; // R3

   // pipeline state
   reg [2:0] op_q;
   reg [2:0] op_d;
   reg [`SBSC_ADDR_W-1:0] base_q;
   reg [1:0] cnt_q;
   reg [1:0] cnt_d;
   reg load_d;
   // stage 2: operation whose data beat is this cycle
   reg [2:0] dop_q;
   reg [`SBSC_ADDR_W-1:0] daddr_q;
   reg [1:0] dbls_q;
   reg [1:0] bls_hold_q;
   reg [`SBSC_WORD_W-1:0] mem [0:`SBSC_DEPTH-1];
   reg [`SBSC_WORD_W-1:0] rword_q;

   wire [1:0] low_addr;
   sbsc_burst_addr u_burst (
      .start_i(base_q[1:0]),
      .count_i(cnt_q),
      .order_i(order),
      .addr_o(low_addr)
   );
   wire [`SBSC_ADDR_W-1:0] cur_addr = {base_q[`SBSC_ADDR_W-1:2], low_addr};

   // cycle classification
   always @* begin
      op_d = op_q;
      cnt_d = cnt_q;
      load_d = 1'b0;
      if (!adv) begin
         if (cs_act) begin
            load_d = 1'b1; // R4
            op_d = wr_n ? OP_READ : OP_WRITE; // R4
            cnt_d = `SBSC_RST_BURST_CNT;
         end else begin
            op_d = OP_IDLE; // R1
         end
      end else if (op_q != OP_IDLE) begin
         cnt_d = cnt_q + 2'h1; // R6 R7
      end
   end

   // write data fifo feeds the store stage
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [`SBSC_WORD_W+`SBSC_ADDR_W+1:0] fifo_out;
   wire [`SBSC_WORD_W+`SBSC_ADDR_W+1:0] fifo_in = {dbls_q, daddr_q, wdata};
   wire wbeat = step & (dop_q == OP_WRITE); // R5
   sbsc_fifo #(
      .WIDTH(`SBSC_WORD_W + `SBSC_ADDR_W + 2),
      .DEPTH(`SBSC_FIFO_DEPTH),
      .AW(`SBSC_FIFO_AW)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .in_valid_i(wbeat),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(1'b1),
      .out_data_o(fifo_out)
   );

   wire [1:0] st_bls = fifo_out[`SBSC_WORD_W+`SBSC_ADDR_W+1:`SBSC_WORD_W+`SBSC_ADDR_W];
   wire [`SBSC_ADDR_W-1:0] st_addr = fifo_out[`SBSC_WORD_W+`SBSC_ADDR_W-1:`SBSC_WORD_W];
   wire [`SBSC_DATA_W-1:0] st_dq = fifo_out[`SBSC_DATA_W-1:0];
   wire [`SBSC_PAR_W-1:0] st_par = fifo_out[`SBSC_WORD_W-1:`SBSC_DATA_W];
   wire [`SBSC_WORD_W-1:0] old_word = mem[st_addr];
   reg [`SBSC_WORD_W-1:0] new_word;

   // lane merge: lane n is dq byte n plus parity bit n
   always @* begin
      new_word = old_word;
      if (!st_bls[0]) begin
         new_word[`SBSC_LANE0_DQ_LSB +: `SBSC_LANE_DQ_W] =
            st_dq[`SBSC_LANE0_DQ_LSB +: `SBSC_LANE_DQ_W]; // R10 R11
         new_word[`SBSC_DATA_W] = st_par[0]; // R11
      end
      if (!st_bls[1]) begin
         new_word[`SBSC_LANE1_DQ_LSB +: `SBSC_LANE_DQ_W] =
            st_dq[`SBSC_LANE1_DQ_LSB +: `SBSC_LANE_DQ_W]; // R10 R11
         new_word[`SBSC_DATA_W+1] = st_par[1]; // R11
      end
   end

   // read bypass: a write still in flight may target the word being read
   wire fwd_head = fifo_out_valid & (st_addr == cur_addr);
   wire fwd_beat = wbeat & (daddr_q == cur_addr);
   wire [`SBSC_WORD_W-1:0] rd_base = fwd_head ? new_word : mem[cur_addr];
   wire [`SBSC_WORD_W-1:0] rd_word;
   genvar gl;
   generate
      for (gl = 0; gl < 2; gl = gl + 1) begin : g_fwd
         wire take = fwd_beat & ~dbls_q[gl];
         assign rd_word[gl*`SBSC_LANE_DQ_W +: `SBSC_LANE_DQ_W] =
            take ? wdata[gl*`SBSC_LANE_DQ_W +: `SBSC_LANE_DQ_W]
                 : rd_base[gl*`SBSC_LANE_DQ_W +: `SBSC_LANE_DQ_W]; // R10 R11
         assign rd_word[`SBSC_DATA_W+gl] =
            take ? wdata[`SBSC_DATA_W+gl] : rd_base[`SBSC_DATA_W+gl]; // R11
      end
   endgenerate

   always @(posedge clk_sys_i) begin
      if (fifo_out_valid) begin
         mem[st_addr] <= new_word; // R10
      end
      // held while suspended so a stalled burst keeps its word
      if (step) begin
         rword_q <= rd_word; // R2
      end
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         op_q <= OP_IDLE; // R13
         cnt_q <= `SBSC_RST_BURST_CNT;
         base_q <= {`SBSC_ADDR_W{1'b0}};
         dop_q <= OP_IDLE; // R13
         daddr_q <= {`SBSC_ADDR_W{1'b0}};
         dbls_q <= 2'h3;
         bls_hold_q <= 2'h3;
      end else if (step) begin
         op_q <= op_d;
         cnt_q <= cnt_d;
         if (load_d) begin
            base_q <= addr; // R4
         end
         // stage 2 takes the current access
         case (op_q)
            OP_READ: dop_q <= OP_READ; // R6
            OP_WRITE: dop_q <= OP_WRITE; // R7
            default: dop_q <= OP_IDLE; // R1
         endcase
         daddr_q <= cur_addr;
         dbls_q <= bls_hold_q; // R7
         bls_hold_q <= bls_n; // R7
      end
   end

   // outputs registered; data driven only in read beat with enable low
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         data_o <= {`SBSC_DATA_W{1'b0}};
         parity_io_o <= {`SBSC_PAR_W{1'b0}};
         data_oe_o <= 1'b0; // R13
         parity_io_oe_o <= 1'b0; // R13
         busy_o <= 1'b0;
      end else begin
         if (step && dop_q == OP_READ) begin
            data_o <= rword_q[`SBSC_DATA_W-1:0]; // R15
            parity_io_o <= rword_q[`SBSC_WORD_W-1:`SBSC_DATA_W];
         end
         // write beat forces off; idle forces off
         data_oe_o <= (dop_q == OP_READ) & ~oe_n; // R12 R16 R1
         parity_io_oe_o <= (dop_q == OP_READ) & ~oe_n; // R12 R16
         busy_o <= (op_q != OP_IDLE) | ~fifo_in_ready;
      end
   end
endmodule // sbsc_core

// [sbsc_core_sva.sv]
module sbsc_core_sva (
   // watched ports
   input wire clk_sys_i,
   input wire rst_i,
   input wire clock_qualify_n_i,
   input wire advance_or_load_i,
   input wire chip_sel1_n_i,
   input wire chip_sel2_i,
   input wire chip_sel3_n_i,
   input wire write_n_i,
   input wire out_drive_n_i,
   input wire [15:0] data_o,
   input wire data_oe_o,
   input wire parity_io_oe_o,
   input wire busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   wire cq = !clock_qualify_n_i;
   wire ld = cq && !advance_or_load_i;
   wire sel = !chip_sel1_n_i && chip_sel2_i && !chip_sel3_n_i;
   wire go = cq && !out_drive_n_i;
   property p_rst;
      disable iff (1'b0) rst_i |=> !data_oe_o && !busy_o;
   endproperty
   a_rst: assert property (p_rst) else $error("live after reset");
   property p_pair;
      data_oe_o == parity_io_oe_o;
   endproperty
   a_pair: assert property (p_pair) else $error("lane enables split");
   property p_odn;
      out_drive_n_i [*5] |-> !data_oe_o;
   endproperty
   a_odn: assert property (p_odn) else $error("drives while disabled");
   property p_desel;
      (ld && !sel) [*6] |=> !data_oe_o;
   endproperty
   a_desel: assert property (p_desel) else $error("drives deselected");
   property p_hold;
      clock_qualify_n_i [*3] |=> $stable(data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("moved in suspend");
   property p_rd;
      ld && sel && write_n_i ##1 go [*4] |=> data_oe_o;
   endproperty
   a_rd: assert property (p_rd) else $error("read not driven");
   property p_rdb;
      ld && sel && write_n_i ##1 (go && advance_or_load_i) [*3] ##1 go [*2] |=> data_oe_o;
   endproperty
   a_rdb: assert property (p_rdb) else $error("burst read stopped");
   property p_wrb;
      ld && sel && !write_n_i ##1 (cq && advance_or_load_i) [*3] ##1 cq |=> !data_oe_o [*2];
   endproperty
   a_wrb: assert property (p_wrb) else $error("drives in write");
endmodule // sbsc_core_sva
bind sbsc_core sbsc_core_sva u_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .clock_qualify_n_i(clock_qualify_n_i), .advance_or_load_i(advance_or_load_i),
   .chip_sel1_n_i(chip_sel1_n_i), .chip_sel2_i(chip_sel2_i), .chip_sel3_n_i(chip_sel3_n_i),
   .write_n_i(write_n_i), .out_drive_n_i(out_drive_n_i), .data_o(data_o),
   .data_oe_o(data_oe_o), .parity_io_oe_o(parity_io_oe_o), .busy_o(busy_o));

// [sbsc_master.sv]
module sbsc_master (
   // clock
   input wire clk_sys_i,
   // pins toward the core
   output logic [9:0] ctl_o,
   output logic [17:0] addr_o,
   output logic [17:0] word_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ctl_o = 10'h0DC;
      addr_o = 18'h00000;
      word_o = 18'h00000;
   end
   // one beat per edge; a released word shows the inverse of the last
   task beat(input logic [9:0] c, input logic [17:0] s, input logic [17:0] v, input logic dr);
      @(posedge clk_sys_i);
      #2;
      ctl_o = c;
      addr_o = s;
      word_o = dr ? v : ~word_o;
   endtask
endmodule // sbsc_master

// [tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [17:0] mem [0:15];
   int fail_count = 0;
   int num_checks = 0;
   wire [9:0] c;
   wire [17:0] a, w;
   wire [15:0] d;
   wire [1:0] po;
   wire oe, poe;
   wire bsy;
   wire [17:0] pin = {poe ? po : w[17:16], oe ? d : w[15:0]};
   always #12.5 clk_sys_i = ~clk_sys_i;
   sbsc_master u_m (.clk_sys_i(clk_sys_i), .ctl_o(c), .addr_o(a), .word_o(w));
   sbsc_core u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clock_qualify_n_i(c[9]),
      .advance_or_load_i(c[8]), .chip_sel1_n_i(c[7]), .chip_sel2_i(c[6]), .chip_sel3_n_i(c[5]),
      .write_n_i(c[4]), .byte_lane_select_n_i(c[3:2]), .burst_order_i(c[1]),
      .out_drive_n_i(c[0]), .addr_i(a), .data_i(pin[15:0]), .data_o(d), .data_oe_o(oe),
      .parity_io_i(pin[17:16]), .parity_io_o(po), .parity_io_oe_o(poe), .busy_o(bsy));
   function logic [3:0] ix(input logic [17:0] s, input int k, input logic o);
      return {s[3:2], o ? s[1:0] ^ 2'(k) : s[1:0] + 2'(k)};
   endfunction
   task chk(input string n, input logic [17:0] s, input logic [17:0] e);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [17:0] s, input logic o, input int n, input logic [1:0] l,
      input logic [17:0] v);
      logic [17:0] m;
      m = {~l[1], ~l[0], {8{~l[1]}}, {8{~l[0]}}};
      for (int i = 0; i < 6; i++) begin
         u_m.beat({1'b0, i > 0 && i < n, i < n ? 3'b010 : 3'b110, 1'b0, l, o, 1'b0}, s,
            v + 18'(i - 2), i >= 2 && i < n + 2);
      end
      for (int k = 0; k < n; k++) begin
         mem[ix(s, k, o)] = (mem[ix(s, k, o)] & ~m) | ((v + 18'(k)) & m);
      end
   endtask
   task rd(input logic [17:0] s, input logic o, input logic [2:0] cs, input logic n);
      logic on;
      on = cs == 3'b010 && !n;
      for (int i = 0; i < 9; i++) begin
         u_m.beat({1'b0, i > 0 && i < 4, i < 4 ? cs : 3'b110, 3'b111, o, n}, s, 18'h00000, 1'b0);
         if (i >= 5) begin
            chk("enable", {17'h00000, oe}, {17'h00000, on});
            chk("busy", {17'h00000, bsy}, {17'h00000, cs == 3'b010 && i < 8});
            if (on) chk("word", {po, d}, mem[ix(s, i - 5, o)]);
         end
      end
   endtask
   task t_burst;
      wr(18'h00000, 1'b0, 4, 2'b00, 18'h2A5C0);
      rd(18'h00000, 1'b0, 3'b010, 1'b0);
      $display("linear burst done");
   endtask
   task t_order;
      wr(18'h00006, 1'b1, 4, 2'b00, 18'h15A30);
      rd(18'h00004, 1'b0, 3'b010, 1'b0);
      rd(18'h00001, 1'b1, 3'b010, 1'b0);
      $display("burst order done");
   endtask
   task t_lanes;
      for (int l = 3; l > 0; l--) wr(18'h00005, 1'b0, 1, 2'(l), 18'h3F0F0 ^ 18'(l));
      rd(18'h00005, 1'b0, 3'b010, 1'b0);
      $display("byte lanes done");
   endtask
   task t_turn;
      for (int i = 0; i < 7; i++) begin
         u_m.beat(i == 0 ? 10'h040 : i == 1 ? 10'h050 : 10'h0DC, 18'h00009, 18'h0C3A5,
            i == 2);
         if (i == 6) chk("turn enable", {17'h00000, oe}, 18'h00001);
         if (i == 6) chk("turn word", {po, d}, 18'h0C3A5);
      end
      mem[9] = 18'h0C3A5;
      $display("write then read done");
   endtask
   task t_sel;
      for (int j = 0; j < 3; j++) rd(18'h00000, 1'b0, 3'b010 ^ 3'(1 << j), 1'b0);
      rd(18'h00000, 1'b0, 3'b010, 1'b1);
      repeat (4) u_m.beat(10'h2DC, 18'h00000, 18'h00000, 1'b0);
      $display("select and suspend done");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_sys_i);
      #2;
      rst_i = 1'b0;
      t_burst;
      t_order;
      t_lanes;
      t_turn;
      t_sel;
      end_of_test;
   end
   initial begin
      #100000;
      fail_count++;
      end_of_test;
   end
endmodule // tb_top
